// ===== rtl/oht_cfg.svh
// Constants of the overheat threshold monitor: offsets, fields, reset values, timing.
`ifndef OHT_CFG_SVH
`define OHT_CFG_SVH

`define OHT_ADDR_CTRL 8'h00
`define OHT_ADDR_ALARM_LEVEL 8'h04
`define OHT_ADDR_WARN_PCT 8'h08
`define OHT_ADDR_FILTER_SEC 8'h0C
`define OHT_ADDR_STATUS 8'h10
`define OHT_ADDR_IRQ_STAT 8'h14
`define OHT_ADDR_IRQ_MASK 8'h18
`define OHT_ADDR_SAMPLE 8'h1C

`define OHT_ALARM_LEVEL_MAX 9'h1F4
`define OHT_ALARM_LEVEL_RST 9'h0FA
`define OHT_WARN_PCT_MAX 7'h64
`define OHT_WARN_PCT_RST 7'h64
`define OHT_FILTER_SEC_RST 16'h0000
`define OHT_PCT_SCALE 24'h000064

`define OHT_IRQ_WARN 0
`define OHT_IRQ_ALARM 1
`define OHT_ST_WARN 0
`define OHT_ST_ALARM 1
`define OHT_ST_FAULT 2
`define OHT_ST_FILT 3

`define OHT_FILTER_UNIT_S 1
`define OHT_CLK_HZ 100000000
`define OHT_TICK_CYCLES (`OHT_FILTER_UNIT_S * `OHT_CLK_HZ)

`endif

// ===== rtl/oht_pkg.sv
// Types shared by the overheat threshold monitor.
package oht_pkg;

    // Encoding order gives selector codes 0..3
    typedef enum logic [1:0] {
        OHT_MODE_OFF,
        OHT_MODE_MOTOR,
        OHT_MODE_NEG,
        OHT_MODE_POS
    } oht_mode_t;

    typedef enum logic [1:0] {
        OHT_FILT_IDLE,
        OHT_FILT_RUN,
        OHT_FILT_ALARM
    } oht_filt_state_t;

    typedef struct packed {
        logic [8:0] alarmLevel;
        logic [6:0] warnPct;
        logic [15:0] filterSec;
    } oht_limits_t;

    typedef struct packed {
        logic valid;
        logic lineFault;
        logic signed [15:0] value;
    } oht_sample_t;

endpackage : oht_pkg

// ===== rtl/oht_sec_tick.sv
// Restartable divider giving a one-cycle enable once per filter time unit.
`timescale 1ns/1ns
`default_nettype none
module oht_sec_tick #(
    parameter int unsigned TICK_CYCLES = 100000000
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic run,
    output logic tick
);
    logic [31:0] count_q;

    // Held at zero while idle so the first period after a start is a full one
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= 32'h00000000;
        end else if (!run || count_q == TICK_CYCLES - 1) begin
            count_q <= 32'h00000000;
        end else begin
            count_q <= count_q + 32'h00000001;
        end
    end

    assign tick = run && (count_q == TICK_CYCLES - 1);
endmodule : oht_sec_tick
`default_nettype wire

// ===== rtl/oht_monitor.sv
// Overheat threshold monitor with Wishbone registers and interrupt.
`timescale 1ns/1ns
`default_nettype none
`include "oht_cfg.svh"
module oht_monitor
    import oht_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `OHT_TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire oht_sample_t thermal_protect_input,
    input wire oht_limits_t motorLimits,
    output logic overheat_warning_event,
    output logic overheat_alarm_event,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////////
    // Register bus
    oht_mode_t overheat_mode_select_q;
    logic [8:0] alarm_voltage_level_q;
    logic [6:0] warning_level_percent_q;
    logic [15:0] alarm_filter_seconds_q;
    logic [1:0] irqStat_q;
    logic [1:0] irqMask_q;
    logic signed [15:0] sample_q;
    logic lineFault_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic busReq;
    logic busWr;
    logic [31:0] wrWord;
    logic [31:0] readMux;
    oht_filt_state_t filtState_q;

    assign busReq = wb_cyc_i && wb_stb_i && !ack_q;
    assign busWr = busReq && wb_we_i;

    // Byte lanes not selected keep the current content
    function automatic logic [31:0] oht_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction : oht_merge

    always_comb begin
        wrWord = 32'h00000000;
        unique case (wb_adr_i)
            `OHT_ADDR_CTRL: wrWord = oht_merge({30'h00000000, overheat_mode_select_q}, wb_dat_i, wb_sel_i);
            `OHT_ADDR_ALARM_LEVEL: wrWord = oht_merge({23'h000000, alarm_voltage_level_q}, wb_dat_i, wb_sel_i);
            `OHT_ADDR_WARN_PCT: wrWord = oht_merge({25'h0000000, warning_level_percent_q}, wb_dat_i, wb_sel_i);
            `OHT_ADDR_FILTER_SEC: wrWord = oht_merge({16'h0000, alarm_filter_seconds_q}, wb_dat_i, wb_sel_i);
            `OHT_ADDR_IRQ_MASK: wrWord = oht_merge({30'h00000000, irqMask_q}, wb_dat_i, wb_sel_i);
            default: wrWord = oht_merge(32'h00000000, wb_dat_i, wb_sel_i);
        endcase
    end

    always_comb begin
        readMux = 32'h00000000;
        unique case (wb_adr_i)
            `OHT_ADDR_CTRL: readMux = {30'h00000000, overheat_mode_select_q};
            `OHT_ADDR_ALARM_LEVEL: readMux = {23'h000000, alarm_voltage_level_q};
            `OHT_ADDR_WARN_PCT: readMux = {25'h0000000, warning_level_percent_q};
            `OHT_ADDR_FILTER_SEC: readMux = {16'h0000, alarm_filter_seconds_q};
            `OHT_ADDR_STATUS: readMux = {28'h0000000, filtState_q == OHT_FILT_RUN, lineFault_q,
                                         overheat_alarm_event, overheat_warning_event};
            `OHT_ADDR_IRQ_STAT: readMux = {30'h00000000, irqStat_q};
            `OHT_ADDR_IRQ_MASK: readMux = {30'h00000000, irqMask_q};
            `OHT_ADDR_SAMPLE: readMux = {16'h0000, sample_q};
            default: readMux = 32'h00000000;
        endcase
    end

    // One wait state; unmapped addresses are acknowledged, read zero and drop writes
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            ack_q <= busReq;
            rdat_q <= busReq ? readMux : 32'h00000000;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // Settings act on the cycle after the write; out of range level, percent and filter values are dropped, the mode takes bits 1:0
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            overheat_mode_select_q <= OHT_MODE_OFF;
            alarm_voltage_level_q <= `OHT_ALARM_LEVEL_RST;
            warning_level_percent_q <= `OHT_WARN_PCT_RST;
            alarm_filter_seconds_q <= `OHT_FILTER_SEC_RST;
        end else if (busWr) begin
            if (wb_adr_i == `OHT_ADDR_CTRL) begin
                overheat_mode_select_q <= oht_mode_t'(wrWord[1:0]);
            end
            if (wb_adr_i == `OHT_ADDR_ALARM_LEVEL && wrWord <= {23'h000000, `OHT_ALARM_LEVEL_MAX}) begin
                alarm_voltage_level_q <= wrWord[8:0];
            end
            if (wb_adr_i == `OHT_ADDR_WARN_PCT && wrWord <= {25'h0000000, `OHT_WARN_PCT_MAX}) begin
                warning_level_percent_q <= wrWord[6:0];
            end
            if (wb_adr_i == `OHT_ADDR_FILTER_SEC && wrWord[31:16] == 16'h0000) begin
                alarm_filter_seconds_q <= wrWord[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Threshold comparison
    logic active;
    logic machineMode;
    logic [8:0] effLevel;
    logic [6:0] effPct;
    logic [15:0] effFilter;
    logic [16:0] magnitude;
    logic overAlarm;
    logic overWarn;
    logic faultAlarm;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sample_q <= 16'sh0000;
            lineFault_q <= 1'b0;
        end else if (thermal_protect_input.valid) begin
            sample_q <= thermal_protect_input.value;
            lineFault_q <= thermal_protect_input.lineFault;
        end
    end

    assign active = overheat_mode_select_q != OHT_MODE_OFF;
    assign machineMode = overheat_mode_select_q == OHT_MODE_NEG || overheat_mode_select_q == OHT_MODE_POS;

    // Motor-held limits replace the local ones in thermostat mode
    always_comb begin
        if (overheat_mode_select_q == OHT_MODE_MOTOR) begin
            effLevel = motorLimits.alarmLevel;
            effPct = motorLimits.warnPct;
            effFilter = motorLimits.filterSec;
        end else begin
            effLevel = alarm_voltage_level_q;
            effPct = warning_level_percent_q;
            effFilter = alarm_filter_seconds_q;
        end
    end

    // Heat drives the voltage negative in mode 2 and positive otherwise
    always_comb begin
        magnitude = 17'h00000;
        if (overheat_mode_select_q == OHT_MODE_NEG) begin
            if (sample_q < 0) begin
                magnitude = 17'(-$signed({sample_q[15], sample_q}));
            end
        end else if (sample_q > 0) begin
            magnitude = {1'b0, sample_q};
        end
    end

    // Scaled by 100 on the sample side to avoid a divider
    assign overAlarm = active && (magnitude > {8'h00, effLevel});
    // Operands widened first so the level times percentage product keeps all its bits
    assign overWarn = active && (({7'h00, magnitude} * `OHT_PCT_SCALE)
                                 > ({15'h0000, effLevel} * {17'h00000, effPct}));
    // The positive sensor cannot tell a broken line from a cold one
    assign faultAlarm = lineFault_q && (overheat_mode_select_q == OHT_MODE_MOTOR
                                        || overheat_mode_select_q == OHT_MODE_NEG);

    ////////////////////////////////////////////////////////////////////////////
    // Alarm filter
    logic secTick;
    logic [15:0] secCount_q;

    oht_sec_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_sec_tick (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .run(filtState_q == OHT_FILT_RUN),
        .tick(secTick)
    );

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            filtState_q <= OHT_FILT_IDLE;
            secCount_q <= 16'h0000;
        end else begin
            unique case (filtState_q)
                OHT_FILT_IDLE: begin
                    secCount_q <= 16'h0000;
                    if (overAlarm) begin
                        filtState_q <= (effFilter == 16'h0000) ? OHT_FILT_ALARM : OHT_FILT_RUN;
                    end
                end
                OHT_FILT_RUN: begin
                    if (!overAlarm) begin
                        filtState_q <= OHT_FILT_IDLE;
                    end else if (secTick) begin
                        secCount_q <= secCount_q + 16'h0001;
                        if (secCount_q + 16'h0001 >= effFilter) begin
                            filtState_q <= OHT_FILT_ALARM;
                        end
                    end
                end
                OHT_FILT_ALARM: begin
                    if (!overAlarm) begin
                        filtState_q <= OHT_FILT_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event outputs and interrupt
    logic warnRise;
    logic alarmRise;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            overheat_warning_event <= 1'b0;
            overheat_alarm_event <= 1'b0;
        end else begin
            overheat_warning_event <= overWarn;
            overheat_alarm_event <= active && (filtState_q == OHT_FILT_ALARM || faultAlarm);
        end
    end

    assign warnRise = overWarn && !overheat_warning_event;
    assign alarmRise = active && (filtState_q == OHT_FILT_ALARM || faultAlarm) && !overheat_alarm_event;

    // A new event in the clearing cycle wins over the clear
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqStat_q <= 2'h0;
            irqMask_q <= 2'h0;
        end else begin
            irqStat_q[`OHT_IRQ_WARN] <= warnRise || (irqStat_q[`OHT_IRQ_WARN]
                && !(busWr && wb_adr_i == `OHT_ADDR_IRQ_STAT && wrWord[`OHT_IRQ_WARN]));
            irqStat_q[`OHT_IRQ_ALARM] <= alarmRise || (irqStat_q[`OHT_IRQ_ALARM]
                && !(busWr && wb_adr_i == `OHT_ADDR_IRQ_STAT && wrWord[`OHT_IRQ_ALARM]));
            if (busWr && wb_adr_i == `OHT_ADDR_IRQ_MASK) begin
                irqMask_q <= wrWord[1:0];
            end
        end
    end

    assign irq = |(irqStat_q & irqMask_q);

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    a_off_no_events: assert property (
        overheat_mode_select_q == OHT_MODE_OFF && $past(overheat_mode_select_q) == OHT_MODE_OFF
        |-> !overheat_warning_event && !overheat_alarm_event)
        else $error("event raised while supervision is off");
    a_warn_follows_level: assert property (
        overWarn |=> overheat_warning_event)
        else $error("warning missed above threshold");
    a_alarm_immediate: assert property (
        overAlarm && effFilter == 16'h0000 && filtState_q == OHT_FILT_IDLE && $stable(effFilter)
        |-> ##1 filtState_q == OHT_FILT_ALARM ##1 overheat_alarm_event)
        else $error("zero filter alarm late");
    a_filter_holds: assert property (
        filtState_q == OHT_FILT_RUN && !faultAlarm |=> !overheat_alarm_event || $past(faultAlarm))
        else $error("alarm before filter time elapsed");
    a_filter_count: assert property (
        filtState_q == OHT_FILT_RUN && overAlarm && secTick && secCount_q + 16'h0001 >= effFilter
        |=> filtState_q == OHT_FILT_ALARM)
        else $error("filter expiry did not alarm");
    a_neg_fault_alarm: assert property (
        overheat_mode_select_q == OHT_MODE_NEG && lineFault_q |=> overheat_alarm_event)
        else $error("broken line missed in negative mode");
    a_motor_fault_alarm: assert property (
        overheat_mode_select_q == OHT_MODE_MOTOR && lineFault_q |=> overheat_alarm_event)
        else $error("broken line missed in thermostat mode");
    a_pos_fault_quiet: assert property (
        overheat_mode_select_q == OHT_MODE_POS && lineFault_q && !overAlarm
        && filtState_q != OHT_FILT_ALARM |=> !overheat_alarm_event)
        else $error("broken line alarmed in positive mode");
    a_motor_limits: assert property (
        overheat_mode_select_q == OHT_MODE_MOTOR |-> effLevel == motorLimits.alarmLevel
        && effFilter == motorLimits.filterSec)
        else $error("local limits used in thermostat mode");
    a_level_write: assert property (
        busWr && wb_adr_i == `OHT_ADDR_ALARM_LEVEL && wb_sel_i == 4'hF && wb_dat_i <= 32'h000001F4
        |=> alarm_voltage_level_q == $past(wb_dat_i[8:0]))
        else $error("alarm level write not taken");
    a_pct_range: assert property (
        warning_level_percent_q <= `OHT_WARN_PCT_MAX && alarm_voltage_level_q <= `OHT_ALARM_LEVEL_MAX)
        else $error("setting out of range");
    a_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    c_warn_seen: cover property (overheat_warning_event && machineMode);
    c_filtered_alarm: cover property (filtState_q == OHT_FILT_RUN ##1 filtState_q == OHT_FILT_ALARM);
    c_fault_alarm: cover property (faultAlarm ##1 overheat_alarm_event);
    c_irq_raised: cover property ($rose(irq));
endmodule : oht_monitor
`default_nettype wire

// ===== verification/oht_sensor_model.sv
// Behavioural temperature sensor front end and motor-held limits feeding the monitor.
`timescale 1ns/1ns
`default_nettype none
module oht_sensor_model
    import oht_pkg::*;
#(
    parameter logic [8:0] MOTOR_LEVEL = 9'h064,
    parameter logic [6:0] MOTOR_PCT = 7'h32,
    parameter logic [15:0] MOTOR_FILT = 16'h0000
) (
    input wire logic core_clk,
    output var oht_sample_t sample,
    output var oht_limits_t limits
);
    assign limits = '{alarmLevel: MOTOR_LEVEL, warnPct: MOTOR_PCT, filterSec: MOTOR_FILT};

    initial begin
        sample = '0;
    end

    // Outside the valid cycle the lines carry the inverse, so unqualified use is caught
    task automatic send(input logic signed [15:0] v, input logic f);
        @(posedge core_clk);
        sample <= '{valid: 1'b1, lineFault: f, value: v};
        @(posedge core_clk);
        sample <= '{valid: 1'b0, lineFault: ~f, value: ~v};
    endtask : send
endmodule : oht_sensor_model
`default_nettype wire

// ===== verification/overheat_threshold_monitor_tb.sv
// Self-checking bench for the overheat threshold monitor.
`timescale 1ns/1ns
`default_nettype none
`include "oht_cfg.svh"
module overheat_threshold_monitor_tb;
    import oht_pkg::*;
    localparam int TICK = 10;
    localparam logic [7:0] ADR_CTL = `OHT_ADDR_CTRL;
    localparam logic [7:0] ADR_LVL = `OHT_ADDR_ALARM_LEVEL;
    localparam logic [7:0] ADR_PCT = `OHT_ADDR_WARN_PCT;
    localparam logic [7:0] ADR_FLT = `OHT_ADDR_FILTER_SEC;
    localparam logic [7:0] ADR_IST = `OHT_ADDR_IRQ_STAT;
    localparam logic [7:0] ADR_MSK = `OHT_ADDR_IRQ_MASK;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'hF;
    logic [31:0] wbDatW = 32'h0;
    logic [31:0] wbDatR;
    logic wbAck;
    logic warnEv;
    logic alarmEv;
    logic irq;
    logic [31:0] rd;
    oht_sample_t sample;
    oht_limits_t limits;
    int n_fail = 0;
    int checks = 0;

    always #5 core_clk = ~core_clk;

    oht_monitor #(.TICK_CYCLES(TICK)) u_dut (.core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
        .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .thermal_protect_input(sample), .motorLimits(limits),
        .overheat_warning_event(warnEv), .overheat_alarm_event(alarmEv), .irq(irq));
    oht_sensor_model u_sens (.core_clk(core_clk), .sample(sample), .limits(limits));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (n_fail == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
        int i;
        @(posedge core_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= sel;
        wbDatW <= dat;
        i = 0;
        do begin
            @(posedge core_clk);
            i++;
        end while (wbAck !== 1'b1 && i < 20);
        if (wbAck !== 1'b1) begin
            chk(32'h0, 32'h1);
            report_and_stop();
        end else begin
            rd = wbDatR;
            wbCyc <= 1'b0;
            wbStb <= 1'b0;
        end
    endtask : wb_xfer

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        wb_xfer(1'b1, adr, 4'hF, dat);
    endtask : wr

    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
        wb_xfer(1'b0, adr, 4'hF, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    task automatic setup(input int m, input int lvl, input int pct, input int flt);
        wr(ADR_CTL, 32'(m));
        wr(ADR_LVL, 32'(lvl));
        wr(ADR_PCT, 32'(pct));
        wr(ADR_FLT, 32'(flt));
    endtask : setup

    // Alarm lands three edges after the valid sample, so four cycles leave margin
    task automatic sense(input logic signed [15:0] v, input logic f);
        u_sens.send(v, f);
        repeat (4) @(posedge core_clk);
    endtask : sense

    task automatic evchk(input logic w, input logic a);
        chk({30'h0, warnEv, alarmEv}, {30'h0, w, a});
    endtask : evchk

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdchk(ADR_CTL, 32'h0);
        rdchk(ADR_LVL, 32'(`OHT_ALARM_LEVEL_RST));
        rdchk(ADR_PCT, 32'(`OHT_WARN_PCT_RST));
        rdchk(ADR_FLT, 32'h0);
        rdchk(ADR_IST, 32'h0);
        rdchk(ADR_MSK, 32'h0);
        evchk(1'b0, 1'b0);
    endtask : t_reset

    task automatic t_ranges();
        wr(ADR_LVL, 32'h1F5);
        rdchk(ADR_LVL, 32'h0FA);
        wr(ADR_LVL, 32'h1F4);
        rdchk(ADR_LVL, 32'h1F4);
        wb_xfer(1'b1, ADR_LVL, 4'h1, 32'h64);
        rdchk(ADR_LVL, 32'h164);
        wr(ADR_PCT, 32'h65);
        rdchk(ADR_PCT, 32'h64);
        wr(ADR_PCT, 32'h0);
        rdchk(ADR_PCT, 32'h0);
        wr(ADR_FLT, 32'h10000);
        rdchk(ADR_FLT, 32'h0);
        wr(ADR_FLT, 32'hFFFF);
        rdchk(ADR_FLT, 32'hFFFF);
        wr(8'h20, 32'h5);
        rdchk(8'h20, 32'h0);
    endtask : t_ranges

    task automatic t_modes();
        setup(0, 100, 50, 0);
        sense(16'sd600, 1'b1);
        evchk(1'b0, 1'b0);
        setup(3, 100, 50, 0);
        sense(16'sd40, 1'b0);
        evchk(1'b0, 1'b0);
        sense(16'sd60, 1'b0);
        evchk(1'b1, 1'b0);
        sense(16'sd150, 1'b0);
        evchk(1'b1, 1'b1);
        wr(ADR_LVL, 32'hC8);
        repeat (3) @(posedge core_clk);
        evchk(1'b1, 1'b0);
        sense(-16'sd150, 1'b0);
        evchk(1'b0, 1'b0);
        sense(16'sd0, 1'b1);
        evchk(1'b0, 1'b0);
        setup(2, 100, 50, 0);
        sense(-16'sd150, 1'b0);
        evchk(1'b1, 1'b1);
        sense(16'sd150, 1'b0);
        evchk(1'b0, 1'b0);
        sense(16'sd0, 1'b1);
        evchk(1'b0, 1'b1);
        rdchk(`OHT_ADDR_STATUS, 32'h6);
        setup(1, 500, 100, 3);
        sense(16'sd60, 1'b0);
        evchk(1'b1, 1'b0);
        sense(16'sd150, 1'b0);
        evchk(1'b1, 1'b1);
        sense(16'sd0, 1'b1);
        evchk(1'b0, 1'b1);
        sense(16'sd0, 1'b0);
    endtask : t_modes

    task automatic t_filter();
        int n;
        setup(3, 100, 100, 2);
        sense(16'sd150, 1'b0);
        evchk(1'b1, 1'b0);
        rdchk(`OHT_ADDR_STATUS, 32'h9);
        // Edges counted from the sample capture; the status read above used three
        n = 7;
        while (alarmEv !== 1'b1 && n < 60) begin
            @(posedge core_clk);
            n++;
        end
        chk(32'(n >= 2 * TICK && n <= 2 * TICK + 6), 32'h1);
        if (alarmEv !== 1'b1) begin
            report_and_stop();
        end else begin
            sense(16'sd0, 1'b0);
            evchk(1'b0, 1'b0);
        end
    endtask : t_filter

    task automatic t_irq();
        setup(3, 100, 50, 0);
        wr(ADR_IST, 32'h3);
        wr(ADR_MSK, 32'h3);
        chk({31'h0, irq}, 32'h0);
        sense(16'sd60, 1'b0);
        rdchk(ADR_IST, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(ADR_MSK, 32'h2);
        @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        wr(ADR_MSK, 32'h3);
        @(posedge core_clk);
        chk({31'h0, irq}, 32'h1);
        wr(ADR_IST, 32'h1);
        @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        sense(16'sd150, 1'b0);
        rdchk(ADR_IST, 32'h2);
        rdchk(`OHT_ADDR_STATUS, 32'h3);
        rdchk(`OHT_ADDR_SAMPLE, 32'h96);
        chk({31'h0, irq}, 32'h1);
    endtask : t_irq

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        t_reset();
        t_ranges();
        t_modes();
        t_filter();
        t_irq();
        report_and_stop();
    end
endmodule : overheat_threshold_monitor_tb
`default_nettype wire
